// *** design/tpc_pkg.sv ***
// Package: register map, control field layout and mode codes of the pulse/capture timer
package tpc_pkg;

   // Register offsets on the plain register port (word addresses)
   localparam logic [2:0] TPC_OFS_CTRL0 = 3'h0;
   localparam logic [2:0] TPC_OFS_CTRL1 = 3'h1;
   localparam logic [2:0] TPC_OFS_COUNT = 3'h2;
   localparam logic [2:0] TPC_OFS_CMPA = 3'h3;
   localparam logic [2:0] TPC_OFS_CMPP = 3'h4;
   localparam logic [2:0] TPC_OFS_FLAGS = 3'h5;

   // Widths
   localparam int TPC_AW = 3;
   localparam int TPC_DW = 16;

   // CTRL0 field positions
   localparam int TPC_C0_RUN = 0;
   localparam int TPC_C0_DIV_LSB = 1;
   localparam int TPC_C0_DIV_MSB = 3;

   // FLAGS field positions
   localparam int TPC_FL_A = 0;
   localparam int TPC_FL_P = 1;

   // timer_mode_select codes
   localparam logic [1:0] TPC_MODE_CMP = 2'h0;
   localparam logic [1:0] TPC_MODE_CAP = 2'h1;
   localparam logic [1:0] TPC_MODE_OUT = 2'h2;
   localparam logic [1:0] TPC_MODE_TMR = 2'h3;

   // pin_action_select codes
   localparam logic [1:0] TPC_PA_00 = 2'h0;
   localparam logic [1:0] TPC_PA_01 = 2'h1;
   localparam logic [1:0] TPC_PA_10 = 2'h2;
   localparam logic [1:0] TPC_PA_11 = 2'h3;

   // Reset values
   localparam logic [3:0] TPC_CTRL0_RST = 4'h0;
   localparam logic [7:0] TPC_CTRL1_RST = 8'h00;
   localparam logic [15:0] TPC_CMPA_RST = 16'h0000;
   localparam logic [7:0] TPC_CMPP_RST = 8'h00;

   // Timing figures of the comparators
   localparam logic [16:0] TPC_FULL_PERIOD = 17'h10000;
   localparam logic [7:0] TPC_LOW_BYTE_ZERO = 8'h00;

   // timer_control_1 layout, msb first
   typedef struct packed {
      logic [1:0] timerModeSelect;
      logic [1:0] pinActionSelect;
      logic outputInitialLevel;
      logic outputPolarityInvert;
      logic periodDutySelect;
      logic clearSourceSelect;
   } tpc_ctrl_t;

   // Register port request bundle
   typedef struct packed {
      logic [TPC_AW-1:0] addr;
      logic [TPC_DW-1:0] wrData;
      logic wrEn;
      logic rdEn;
   } tpc_req_t;

endpackage

// *** design/tpc_timer.sv ***
// Module: 16-bit timer with PWM output, single-pulse output and input capture
`timescale 1ns/1ps

// Summary of operation
// - PWM, selector 0: compare P sets period P*256 or 65536; A sets duty.
// - PWM, selector 1: A sets period; duty P*256, or 65536 when P is 0.
// - Duty at or above period gives a fully active PWM output.
// - Pin action 00 or 01 forces the pin while PWM counting continues.
// - Clear source select is ignored in PWM; selector alone picks the clear.
// - Single pulse: run bit rising starts counter and drives the leading edge.
// - Single pulse: trigger pin active edge sets the run bit automatically.
// - Single pulse: trailing edge when run clears, by software or compare A.
// - Single pulse: compare A match clears run and raises the timer flag.
// - Single pulse: counter returns to zero only when run rises.
// - Single pulse ignores compare P, clear source and period selector.
// - Capture: counter starts on run rising, runs until run falls.
// - Capture: selected edge copies counter into compare A, raises flag.
// - Capture: compare P match clears counter, raises flag P; P zero runs to maximum.
// - Capture: pin action 11 disables capture while the counter keeps running.
// - Capture: no output; level, invert, clear source and selector ignored.
// - PWM: initial level sets base polarity, invert flips the pin waveform.
module tpc_timer (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire tpc_pkg::tpc_req_t busReq,
   output logic [tpc_pkg::TPC_DW-1:0] rdData,
   input wire logic ext_trigger_pin,
   input wire logic capture_input_pin,
   output logic timerOutPin,
   output logic [1:0] eventFlags
);
   import tpc_pkg::*;

   // Mask of low divider bits that must all be set for a timer tick
   function automatic logic [7:0] divMask(input logic [2:0] sel);
      divMask = 8'((9'h001 << sel) - 9'h001);
   endfunction

   // Output level for a given active state, with base level and inversion
   function automatic logic pinLevel(input logic active, input tpc_ctrl_t c);
      pinLevel = (active ? c.outputInitialLevel : ~c.outputInitialLevel)
                 ^ c.outputPolarityInvert;
   endfunction

   // Capture edge qualifier
   function automatic logic capEdge(input logic [1:0] pa, input logic rise,
                                    input logic fall);
      unique case (pa)
         TPC_PA_00: capEdge = rise;
         TPC_PA_01: capEdge = fall;
         TPC_PA_10: capEdge = rise | fall;
         TPC_PA_11: capEdge = 1'b0;
      endcase
   endfunction

   tpc_ctrl_t ctrl;
   logic [2:0] divSel;
   logic counterRun;
   logic runPrev;
   logic runRise;
   logic [7:0] divCnt;
   logic tick;
   logic [15:0] counter;
   logic [15:0] compareA;
   logic [7:0] compareP;
   logic trigPrev;
   logic capPrev;
   logic trigRise;
   logic capRise;
   logic capFall;
   logic modePwm;
   logic modeSingle;
   logic modeCap;
   logic [15:0] pLast;
   logic [16:0] pSpan;
   logic [16:0] pwmPeriod;
   logic [16:0] pwmDuty;
   logic pwmActive;
   logic aMatch;
   logic pMatch;
   logic periodEnd;
   logic capEvent;
   logic wrCtrl0;
   logic wrCtrl1;
   logic wrCmpA;
   logic wrCmpP;
   logic wrFlags;
   logic [TPC_DW-1:0] next_rdData;
   logic next_outPin;

   // Write decode
   assign wrCtrl0 = busReq.wrEn && (busReq.addr == TPC_OFS_CTRL0);
   assign wrCtrl1 = busReq.wrEn && (busReq.addr == TPC_OFS_CTRL1);
   assign wrCmpA = busReq.wrEn && (busReq.addr == TPC_OFS_CMPA);
   assign wrCmpP = busReq.wrEn && (busReq.addr == TPC_OFS_CMPP);
   assign wrFlags = busReq.wrEn && (busReq.addr == TPC_OFS_FLAGS);

   // Mode decode; single pulse and PWM share mode 10, split by pin action
   assign modeCap = (ctrl.timerModeSelect == TPC_MODE_CAP);
   assign modeSingle = (ctrl.timerModeSelect == TPC_MODE_OUT)
                       && (ctrl.pinActionSelect == TPC_PA_11);
   assign modePwm = (ctrl.timerModeSelect == TPC_MODE_OUT)
                    && (ctrl.pinActionSelect != TPC_PA_11);

   // Timer clock is an enable pulse from the prescaler
   assign tick = ((divCnt & divMask(divSel)) == divMask(divSel));

   // Pins are taken as synchronous; one register gives the edge history
   assign trigRise = ext_trigger_pin & ~trigPrev;
   assign capRise = capture_input_pin & ~capPrev;
   assign capFall = ~capture_input_pin & capPrev;
   assign runRise = counterRun & ~runPrev;

   // Compare P span: P*256, zero means the full 65536 count
   assign pSpan = (compareP == TPC_LOW_BYTE_ZERO) ? TPC_FULL_PERIOD
                  : {1'b0, compareP, TPC_LOW_BYTE_ZERO};
   // Last count before a P clear; P of zero wraps to FFFF, the maximum
   assign pLast = 16'({compareP, TPC_LOW_BYTE_ZERO} - 16'h0001);

   // Period from P, duty from A
   // Period from A, duty from P
   always_comb begin
      if (ctrl.periodDutySelect) begin
         pwmPeriod = {1'b0, compareA};
         pwmDuty = pSpan;
      end else begin
         pwmPeriod = pSpan;
         pwmDuty = {1'b0, compareA};
      end
   end

   assign pwmActive = (pwmDuty >= pwmPeriod) || ({1'b0, counter} < pwmDuty);

   // Comparator events, only on a timer tick while running
   // The restart cycle is masked: the counter still holds the stale count of the
   // last run there, and a match on it would end a pulse before it began
   assign aMatch = counterRun && tick && !runRise && (counter == compareA);
   assign pMatch = counterRun && tick && !runRise && (counter == pLast);

   // Limitation: a period shortened below the running count lets the counter
   // wrap through FFFF once before the new period takes hold
   // PWM clear chosen by selector only; clear source not consulted
   // Single pulse never clears on a compare
   always_comb begin
      if (modePwm) begin
         periodEnd = counterRun && tick
                     && ({1'b0, counter} == 17'(pwmPeriod - 17'h00001));
      end else if (modeSingle) begin
         periodEnd = 1'b0;
      end else begin
         periodEnd = pMatch;
      end
   end

   // Pin action 11 yields no capture
   assign capEvent = modeCap && counterRun
                     && capEdge(ctrl.pinActionSelect, capRise, capFall);

   // Prescaler divider; free running so the tick phase is independent of run
   // A select of 0 gives an all-zero mask, so the timer ticks on every clock
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         divCnt <= 8'h00;
      end else begin
         divCnt <= divCnt + 8'h01;
      end
   end

   // Edge history registers for pins and run bit
   // Reset values equal the idle low level of the pins, so no false edge follows reset
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         trigPrev <= 1'b0;
         capPrev <= 1'b0;
         runPrev <= 1'b0;
      end else begin
         trigPrev <= ext_trigger_pin;
         capPrev <= capture_input_pin;
         runPrev <= counterRun;
      end
   end

   // Control registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl <= TPC_CTRL1_RST;
         divSel <= TPC_CTRL0_RST[TPC_C0_DIV_MSB:TPC_C0_DIV_LSB];
         compareP <= TPC_CMPP_RST;
      end else begin
         if (wrCtrl1) begin
            ctrl <= busReq.wrData[7:0];
         end
         if (wrCtrl0) begin
            divSel <= busReq.wrData[TPC_C0_DIV_MSB:TPC_C0_DIV_LSB];
         end
         if (wrCmpP) begin
            compareP <= busReq.wrData[7:0];
         end
      end
   end

   // Run bit: software write, hardware clear, trigger set; set wins last
   // A trigger in the cycle of a clear keeps run set; with no run rise the counter is not zeroed, so the pulse runs on
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         counterRun <= TPC_CTRL0_RST[TPC_C0_RUN];
      end else begin
         if (wrCtrl0) begin
            counterRun <= busReq.wrData[TPC_C0_RUN];
         end
         if (modeSingle && aMatch) begin
            counterRun <= 1'b0;
         end
         if (modeSingle && trigRise) begin
            counterRun <= 1'b1;
         end
      end
   end

   // Counter: zeroed on run rising, counts timer ticks while run is high
   // A stopped counter holds its count, so software can read where it ended
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         counter <= 16'h0000;
      end else begin
         if (runRise) begin
            counter <= 16'h0000;
         end else if (counterRun && tick) begin
            if (periodEnd) begin
               counter <= 16'h0000;
            end else begin
               counter <= counter + 16'h0001;
            end
         end
      end
   end

   // Compare A: software value, overwritten by a capture, which wins
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         compareA <= TPC_CMPA_RST;
      end else begin
         if (wrCmpA) begin
            compareA <= busReq.wrData;
         end
         // An edge in the restart cycle latches the fresh zero, not the stale count
         // Latch counter
         if (capEvent) begin
            compareA <= runRise ? 16'h0000 : counter;
         end
      end
   end

   // Sticky flags; write one to clear, a same-cycle event keeps the flag set
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         eventFlags <= 2'b00;
      end else begin
         if (wrFlags) begin
            eventFlags <= eventFlags & ~busReq.wrData[1:0];
         end
         if ((aMatch && !modeCap) || capEvent) begin
            eventFlags[TPC_FL_A] <= 1'b1;
         end
         // Compare P is unused in single pulse, so no P flag is raised there
         // P match flag
         if (pMatch && !modeSingle) begin
            eventFlags[TPC_FL_P] <= 1'b1;
         end
      end
   end

   // Pin level for each mode
   always_comb begin
      next_outPin = 1'b0;
      if (modePwm) begin
         unique case (ctrl.pinActionSelect)
            TPC_PA_00: next_outPin = pinLevel(1'b0, ctrl);
            TPC_PA_01: next_outPin = pinLevel(1'b1, ctrl);
            default: next_outPin = pinLevel(counterRun && pwmActive, ctrl);
         endcase
      end else if (modeSingle) begin
         next_outPin = pinLevel(counterRun, ctrl);
      end else begin
         next_outPin = 1'b0;
      end
   end

   // Registered pin, one cycle behind the counter state
   // The register costs one cycle of latency but keeps decode glitches off the pin
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         timerOutPin <= 1'b0;
      end else begin
         timerOutPin <= next_outPin;
      end
   end

   // Read mux; unmapped offsets read zero
   // COUNT has no write decode, so it stays read-only to software
   always_comb begin
      unique case (busReq.addr)
         TPC_OFS_CTRL0: next_rdData = {12'h000, divSel, counterRun};
         TPC_OFS_CTRL1: next_rdData = {8'h00, ctrl};
         TPC_OFS_COUNT: next_rdData = counter;
         TPC_OFS_CMPA: next_rdData = compareA;
         TPC_OFS_CMPP: next_rdData = {8'h00, compareP};
         TPC_OFS_FLAGS: next_rdData = {14'h0000, eventFlags};
         default: next_rdData = 16'h0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdData <= 16'h0000;
      end else if (busReq.rdEn) begin
         rdData <= next_rdData;
      end else begin
         rdData <= 16'h0000;
      end
   end

endmodule // tpc_timer

// *** bench/tpc_timer_sva.sv ***
// Checker: port-level assertions for the pulse/capture timer
`timescale 1ns/1ps
module tpc_timer_sva (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire tpc_pkg::tpc_req_t busReq,
   input wire logic [tpc_pkg::TPC_DW-1:0] rdData,
   input wire logic ext_trigger_pin,
   input wire logic capture_input_pin,
   input wire logic timerOutPin,
   input wire logic [1:0] eventFlags
);
   import tpc_pkg::*;
   tpc_ctrl_t cfg;
   logic [1:0] age;
   logic runSh;
   logic isPwm;
   logic isSp;
   logic isCap;
   logic clrA;
   logic clrP;
   logic c0Wr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Shadow of the mode register and the software run bit
   always_ff @(posedge clk_sys) begin
      if (sys_rst) cfg <= '0;
      else if (busReq.wrEn && busReq.addr == TPC_OFS_CTRL1) cfg <= busReq.wrData[7:0];
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) runSh <= 1'b0;
      else if (c0Wr) runSh <= busReq.wrData[TPC_C0_RUN];
   end
   // Age since a control write; the registered pin needs a few cycles to settle
   always_ff @(posedge clk_sys) begin
      if (sys_rst || (busReq.wrEn && busReq.addr <= TPC_OFS_CTRL1)) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
   end
   assign c0Wr = busReq.wrEn && busReq.addr == TPC_OFS_CTRL0;
   assign clrA = busReq.wrEn && busReq.addr == TPC_OFS_FLAGS && busReq.wrData[TPC_FL_A];
   assign clrP = busReq.wrEn && busReq.addr == TPC_OFS_FLAGS && busReq.wrData[TPC_FL_P];
   assign isPwm = age == 2'h3 && cfg.timerModeSelect == TPC_MODE_OUT;
   assign isSp = isPwm && cfg.pinActionSelect == TPC_PA_11;
   assign isCap = age == 2'h3 && cfg.timerModeSelect == TPC_MODE_CAP;
   chk_flag_a_hold: assert property (
      $fell(eventFlags[0]) |-> $past(clrA)) else $error("flag A dropped without a clear");
   chk_flag_p_hold: assert property (
      $fell(eventFlags[1]) |-> $past(clrP)) else $error("flag P dropped without a clear");
   chk_pwm_force_low: assert property (
      isPwm && runSh && cfg.pinActionSelect == TPC_PA_00
      |-> timerOutPin == (!cfg.outputInitialLevel ^ cfg.outputPolarityInvert))
      else $error("forced inactive level wrong");
   chk_pwm_force_high: assert property (
      isPwm && runSh && cfg.pinActionSelect == TPC_PA_01
      |-> timerOutPin == (cfg.outputInitialLevel ^ cfg.outputPolarityInvert))
      else $error("forced active level wrong");
   chk_cap_no_output: assert property (
      isCap |-> !timerOutPin) else $error("pin driven in capture mode");
   chk_cap_edge_flag: assert property (
      isCap && runSh && ((cfg.pinActionSelect == TPC_PA_00 && $rose(capture_input_pin))
      || (cfg.pinActionSelect == TPC_PA_01 && $fell(capture_input_pin))
      || (cfg.pinActionSelect == TPC_PA_10 && $changed(capture_input_pin)))
      |-> ##[1:2] eventFlags[0]) else $error("selected edge gave no capture flag");
   chk_cap_none: assert property (
      isCap && cfg.pinActionSelect == TPC_PA_11 |=> !$rose(eventFlags[0]))
      else $error("capture while disabled");
   chk_pulse_sw_start: assert property (
      isSp && c0Wr && busReq.wrData[TPC_C0_RUN] |-> ##[1:3] timerOutPin)
      else $error("no leading edge after run set");
   chk_pulse_sw_end: assert property (
      isSp && c0Wr && !busReq.wrData[TPC_C0_RUN] && !ext_trigger_pin |-> ##[1:3] !timerOutPin)
      else $error("no trailing edge after run clear");
   chk_pulse_trigger: assert property (
      isSp && $rose(ext_trigger_pin) |-> ##[1:4] timerOutPin)
      else $error("trigger edge gave no pulse");
endmodule // tpc_timer_sva

bind tpc_timer tpc_timer_sva tpc_timer_sva_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .busReq(busReq), .rdData(rdData), .ext_trigger_pin(ext_trigger_pin),
   .capture_input_pin(capture_input_pin), .timerOutPin(timerOutPin), .eventFlags(eventFlags));

// *** bench/tpc_pins_model.sv ***
// Partner model: external trigger source and measured capture signal
`timescale 1ns/1ps
module tpc_pins_model (
   input wire logic clk_sys,
   output logic ext_trigger_pin,
   output logic capture_input_pin
);
   // Both lines rest low until commanded
   initial begin
      ext_trigger_pin = 1'b0;
      capture_input_pin = 1'b0;
   end
   // Short trigger pulse after a chosen delay, prompt or slow
   task automatic trig(input int dly);
      repeat (dly) @(posedge clk_sys);
      ext_trigger_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ext_trigger_pin <= 1'b0;
   endtask
   // Measured signal moves to a new level after a delay
   task automatic cap(input logic lvl, input int dly);
      repeat (dly) @(posedge clk_sys);
      capture_input_pin <= lvl;
   endtask
endmodule // tpc_pins_model

// *** bench/tpc_timer_bench.sv ***
// Testbench: register-level scenarios for the pulse/capture timer
`timescale 1ns/1ps
module tpc_timer_bench;
   import tpc_pkg::*;
   logic clk_sys;
   logic sys_rst;
   tpc_req_t busReq;
   logic [TPC_DW-1:0] rdData;
   logic ext_trigger_pin;
   logic capture_input_pin;
   logic timerOutPin;
   logic [1:0] eventFlags;
   int n_errors;
   int check_count;
   int h;
   int k;
   logic [15:0] v;
   logic [15:0] v2;
   tpc_timer tpc_timer_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .busReq(busReq),
      .rdData(rdData), .ext_trigger_pin(ext_trigger_pin), .capture_input_pin(capture_input_pin),
      .timerOutPin(timerOutPin), .eventFlags(eventFlags));
   tpc_pins_model tpc_pins_model_inst (.clk_sys(clk_sys), .ext_trigger_pin(ext_trigger_pin),
      .capture_input_pin(capture_input_pin));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      if (n_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus cycles: strobe for one edge, then one idle edge so strobes never double up
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      busReq.addr <= a;
      busReq.wrData <= d;
      busReq.wrEn <= 1'b1;
      @(posedge clk_sys);
      busReq.wrEn <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      busReq.addr <= a;
      busReq.rdEn <= 1'b1;
      @(posedge clk_sys);
      busReq.rdEn <= 1'b0;
      #1 d = rdData;
      @(posedge clk_sys);
   endtask
   task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
      rd(a, v);
      check(v, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Outputs are sampled mid-cycle, away from the launching edge; 2 selects the pin
   task automatic probe(input int idx, input logic exp);
      @(negedge clk_sys);
      check({15'h0000, idx == 2 ? timerOutPin : eventFlags[idx]}, {15'h0000, exp});
      @(posedge clk_sys);
   endtask
   task automatic hi(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(negedge clk_sys);
         if (timerOutPin === 1'b1) c++;
      end
      @(posedge clk_sys);
   endtask
   // Pulse width in cycles; a pulse that never ends stops the run
   task automatic pw(output int c);
      int i;
      c = 0;
      for (i = 0; i < 400; i++) begin
         @(negedge clk_sys);
         if (timerOutPin === 1'b1) c++;
         else if (c > 0) break;
      end
      @(posedge clk_sys);
      if (i == 400) begin
         n_errors++;
         print_verdict();
      end
   endtask
   function automatic logic [15:0] c1(logic [1:0] m, logic [1:0] pa, logic ini, logic inv,
      logic dpx, logic ccl);
      return {8'h00, m, pa, ini, inv, dpx, ccl};
   endfunction
   initial begin
      sys_rst = 1'b1;
      busReq = '0;
      n_errors = 0;
      check_count = 0;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // Zero after reset everywhere; 6 and 7 unmapped, count read-only
      for (k = 0; k < 8; k++) rdc(3'(k), 16'h0000);
      wr(TPC_OFS_CMPP, 16'h12FF);
      wr(TPC_OFS_COUNT, 16'h1234);
      wr(3'h6, 16'hFFFF);
      rdc(TPC_OFS_CMPP, 16'h00FF);
      rdc(TPC_OFS_COUNT, 16'h0000);
      rdc(3'h6, 16'h0000);
      // PWM from compare P period 256 and duty 64, every polarity pair
      wr(TPC_OFS_CMPP, 16'h0001);
      wr(TPC_OFS_CMPA, 16'h0040);
      wr(TPC_OFS_CTRL0, 16'h0001);
      for (k = 0; k < 4; k++) begin
         wr(TPC_OFS_CTRL1, c1(TPC_MODE_OUT, TPC_PA_10, k[1], k[0], 1'b0, 1'b1));
         idle(8);
         hi(512, h);
         check(16'(h), (k[1] ^ k[0]) ? 16'h0080 : 16'h0180);
      end
      wr(TPC_OFS_CTRL1, c1(TPC_MODE_OUT, TPC_PA_10, 1'b1, 1'b0, 1'b0, 1'b1));
      wr(TPC_OFS_CMPA, 16'h0100);
      idle(260);
      hi(512, h);
      check(16'(h), 16'h0200);
      wr(TPC_OFS_CTRL1, c1(TPC_MODE_OUT, TPC_PA_00, 1'b1, 1'b0, 1'b0, 1'b1));
      wr(TPC_OFS_FLAGS, 16'h0003);
      hi(300, h);
      check(16'(h), 16'h0000);
      probe(1, 1'b1);
      wr(TPC_OFS_CTRL1, c1(TPC_MODE_OUT, TPC_PA_01, 1'b1, 1'b0, 1'b0, 1'b1));
      idle(4);
      hi(256, h);
      check(16'(h), 16'h0100);
      // Selector 1: period 300 from compare A, duty from compare P
      wr(TPC_OFS_CMPA, 16'h012C);
      wr(TPC_OFS_CTRL1, c1(TPC_MODE_OUT, TPC_PA_10, 1'b1, 1'b0, 1'b1, 1'b0));
      idle(310);
      hi(600, h);
      check(16'(h), 16'h0200);
      wr(TPC_OFS_CMPP, 16'h0000);
      idle(310);
      hi(600, h);
      check(16'(h), 16'h0258);
      // Single pulse of width set by compare A, started by software then by trigger
      wr(TPC_OFS_CTRL0, 16'h0000);
      wr(TPC_OFS_CMPA, 16'h0014);
      wr(TPC_OFS_CMPP, 16'h0001);
      wr(TPC_OFS_CTRL1, c1(TPC_MODE_OUT, TPC_PA_11, 1'b1, 1'b0, 1'b1, 1'b1));
      wr(TPC_OFS_FLAGS, 16'h0003);
      wr(TPC_OFS_CTRL0, 16'h0001);
      pw(h);
      check(16'(h > 20 && h < 24), 16'h0001);
      probe(0, 1'b1);
      rdc(TPC_OFS_CTRL0, 16'h0000);
      rd(TPC_OFS_COUNT, v2);
      idle(20);
      rdc(TPC_OFS_COUNT, v2);
      wr(TPC_OFS_FLAGS, 16'h0003);
      fork
         tpc_pins_model_inst.trig(2);
         pw(h);
      join
      check(16'(h > 20 && h < 24), 16'h0001);
      probe(0, 1'b1);
      rdc(TPC_OFS_COUNT, v2);
      // Software clear ends a long pulse early, with no compare flag
      wr(TPC_OFS_CMPA, 16'h00C8);
      wr(TPC_OFS_FLAGS, 16'h0003);
      wr(TPC_OFS_CTRL0, 16'h0001);
      idle(10);
      wr(TPC_OFS_CTRL0, 16'h0000);
      idle(3);
      probe(2, 1'b0);
      probe(0, 1'b0);
      // Capture with period 256 and every edge selection
      wr(TPC_OFS_CMPA, 16'hFFFF);
      wr(TPC_OFS_CTRL1, c1(TPC_MODE_CAP, TPC_PA_00, 1'b1, 1'b1, 1'b1, 1'b1));
      wr(TPC_OFS_CTRL0, 16'h0001);
      probe(2, 1'b0);
      for (k = 0; k < 4; k++) begin
         wr(TPC_OFS_CTRL1, c1(TPC_MODE_CAP, 2'(k), 1'b1, 1'b1, 1'b1, 1'b1));
         wr(TPC_OFS_FLAGS, 16'h0003);
         tpc_pins_model_inst.cap(1'b1, 0);
         idle(4);
         probe(0, k == 0 || k == 2);
         wr(TPC_OFS_FLAGS, 16'h0003);
         tpc_pins_model_inst.cap(1'b0, 0);
         idle(4);
         probe(0, k == 1 || k == 2);
      end
      rd(TPC_OFS_CMPA, v);
      check(16'(v < 16'h0100), 16'h0001);
      rd(TPC_OFS_COUNT, v);
      rd(TPC_OFS_COUNT, v2);
      check(16'(v != v2), 16'h0001);
      wr(TPC_OFS_FLAGS, 16'h0003);
      idle(300);
      probe(1, 1'b1);
      wr(TPC_OFS_CTRL0, 16'h0000);
      rd(TPC_OFS_COUNT, v);
      idle(5);
      rdc(TPC_OFS_COUNT, v);
      print_verdict();
   end
endmodule // tpc_timer_bench
